// *** hdl/fots_regs.svh ***
/*
  Timing constants and register values for the flash operation timeout supervisor.
  Assumes a 125 MHz controller clock; times are kept in their own units.
*/
`ifndef FOTS_REGS_SVH
`define FOTS_REGS_SVH

`define FOTS_CLK_PERIOD_PS      8000
`define FOTS_NOTIFY_TIME_US     60
`define FOTS_NOTIFY_WAIT_US     180
`define FOTS_RESET_MIN_US       35
`define FOTS_RESET_WAIT_US      105
`define FOTS_ERASE_TYP_MS       800
`define FOTS_ERASE_MAX_MS       1750
`define FOTS_ERASE_WAIT_MS      5775
`define FOTS_PROG_TYP_MS        2
`define FOTS_PROG_MAX_MS        12
`define FOTS_PROG_WAIT_US       39600
`define FOTS_US_TO_CYC(t)       (32'(((t) * 64'd1000000 + `FOTS_CLK_PERIOD_PS - 1) / `FOTS_CLK_PERIOD_PS))
`define FOTS_NOTIFY_WAIT_CYC    `FOTS_US_TO_CYC(`FOTS_NOTIFY_WAIT_US)
`define FOTS_RESET_WAIT_CYC     `FOTS_US_TO_CYC(`FOTS_RESET_WAIT_US)
`define FOTS_ERASE_WAIT_CYC     `FOTS_US_TO_CYC(`FOTS_ERASE_WAIT_MS * 1000)
`define FOTS_PROG_WAIT_CYC      `FOTS_US_TO_CYC(`FOTS_PROG_WAIT_US)
`define FOTS_READ_MODE_VALUE    16'hAA00
`define FOTS_ERR_NOTIFY         0
`define FOTS_ERR_ERASE          1
`define FOTS_ERR_PROG           2
`define FOTS_ERR_READMODE       3

`endif

// *** hdl/fots_pkg.sv ***
/*
  Types for the flash operation timeout supervisor.
  Assumes fots_regs.svh provides the numeric constants.
*/
package fots_pkg;
  typedef enum logic [1:0] {
    FOTS_OP_NOTIFY,
    FOTS_OP_ERASE,
    FOTS_OP_PROG,
    FOTS_OP_READMODE
  } fots_op_t;
  typedef enum logic [2:0] {
    FOTS_IDLE,
    FOTS_RESET_HOLD,
    FOTS_WAIT_READY,
    FOTS_WRITE_MODE,
    FOTS_DONE
  } fots_state_t;
endpackage

// *** hdl/fots_supervisor.sv ***
/*
  Controller-side supervisor that times flash unit commands against ready and
  drives the flash reset bit with a measured pulse.
  Assumes the flash unit's ready flag is synchronous to clk and that command
  issue is signalled by the user one cycle pulse op_start.
*/
// Summary of operation
// - A notify that is not ready within its window reinitialises the flash unit and reports an error.
// - The notify window is 180 us, three times the 60 us notify time.
// - The flash reset bit stays at 1 for at least 35 us before returning to 0.
// - The reset hold actually used is the wider 105 us.
// - Return to read mode waits for ready under the erase window, then writes AA00h to the mode entry register.
// - A block erase is timed from its command until ready rises.
// - The erase window is 5775 ms before an erase failure is declared.
// - Each 256 byte program is timed from its command until ready, failing on timeout.
// - The program window is 39.6 ms before a program failure is declared.
// - Windows are counted in controller clock cycles derived from the time and the clock period.
// - All waits are measured by a hardware counter, never by instruction timing.
// - Initialisation drives the reset bit of the flash reset register.
`timescale 1ns/1ps
`include "fots_regs.svh"

module fots_supervisor #(
  parameter int unsigned NOTIFY_CYC = `FOTS_NOTIFY_WAIT_CYC,
  parameter int unsigned RESET_CYC  = `FOTS_RESET_WAIT_CYC,
  parameter int unsigned ERASE_CYC  = `FOTS_ERASE_WAIT_CYC,
  parameter int unsigned PROG_CYC   = `FOTS_PROG_WAIT_CYC
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             op_start,
  input  wire fots_pkg::fots_op_t op_kind,
  input  wire logic             init_start,
  input  wire logic             err_ack,
  input  wire logic             flash_ready_flag,
  output logic                  flash_reset_bit,
  output logic                  mode_entry_we,
  output logic [15:0]           mode_entry_data,
  output logic                  busy,
  output logic                  op_done,
  output logic [3:0]            err_flags
);
  import fots_pkg::*;

  // The reset hold check counts eight cycles, so shorter holds are refused
  if (NOTIFY_CYC < 1 || RESET_CYC < 8 || ERASE_CYC < 1 || PROG_CYC < 1) begin : g_bad_wait
    $error("fots_supervisor: wait counts below the supported minimum");
  end

  fots_state_t  state;
  fots_state_t  next_state;
  fots_op_t     cur_op;
  logic [31:0]  count;
  logic [31:0]  limit;
  logic [3:0]   err_set;

  assign limit = (cur_op == FOTS_OP_NOTIFY) ? NOTIFY_CYC :
                 (cur_op == FOTS_OP_PROG)   ? PROG_CYC   : ERASE_CYC;

  wire expired  = (count >= limit - 32'd1);
  wire hold_end = (count >= RESET_CYC - 32'd1);
  wire timeout  = (state == FOTS_WAIT_READY) && !flash_ready_flag && expired;
  wire ready_ok = (state == FOTS_WAIT_READY) && flash_ready_flag;

  always_comb begin
    next_state = state;
    case (state)
      FOTS_IDLE:
        if (init_start)
          next_state = FOTS_RESET_HOLD;
        else if (op_start)
          next_state = FOTS_WAIT_READY;
      FOTS_RESET_HOLD:
        if (hold_end)
          next_state = FOTS_DONE;
      FOTS_WAIT_READY:
        if (ready_ok)
          next_state = (cur_op == FOTS_OP_READMODE) ? FOTS_WRITE_MODE : FOTS_DONE;
        else if (timeout)
          next_state = (cur_op == FOTS_OP_NOTIFY) ? FOTS_RESET_HOLD : FOTS_DONE;
      FOTS_WRITE_MODE:
        next_state = FOTS_DONE;
      FOTS_DONE:
        next_state = FOTS_IDLE;
      default:
        next_state = FOTS_IDLE;
    endcase
  end

  always_comb begin
    err_set = 4'h0;
    if (timeout)
      err_set[cur_op] = 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= FOTS_IDLE;
      cur_op <= FOTS_OP_NOTIFY;
    end else begin
      state <= next_state;
      if (state == FOTS_IDLE && op_start && !init_start)
        cur_op <= op_kind;
    end
  end

  // hardware cycle counter, cleared on each state change, so zero in the cycle after the command
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      count <= 32'h0;
    else if (state != next_state)
      count <= 32'h0;
    else
      count <= count + 32'h1;
  end

  // reset bit driven only while holding
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      flash_reset_bit <= 1'b0;
    else
      flash_reset_bit <= (next_state == FOTS_RESET_HOLD);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_entry_we   <= 1'b0;
      mode_entry_data <= 16'h0000;
    end else begin
      mode_entry_we   <= (next_state == FOTS_WRITE_MODE);
      mode_entry_data <= (next_state == FOTS_WRITE_MODE) ? `FOTS_READ_MODE_VALUE : 16'h0000;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      err_flags <= 4'h0;
    else
      err_flags <= (err_ack ? 4'h0 : err_flags) | err_set;
  end

  assign busy    = (state != FOTS_IDLE);
  assign op_done = (state == FOTS_DONE);

  property p_reset_hold;
    @(posedge clk) disable iff (reset)
      $rose(flash_reset_bit) |-> flash_reset_bit [*8];
  endproperty
  // Short window; the full length is covered by the counter check
  a_reset_hold: assert property (p_reset_hold) else $error("reset pulse too short");

  property p_hold_len;
    @(posedge clk) disable iff (reset)
      $fell(flash_reset_bit) |-> $past(count) == RESET_CYC - 32'd1;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("reset hold below 105 us");

  // Reinit and its error flag start on the same edge
  sequence s_reinit;
    flash_reset_bit && err_flags[`FOTS_ERR_NOTIFY];
  endsequence

  property p_notify_reinit;
    @(posedge clk) disable iff (reset)
      (timeout && cur_op == FOTS_OP_NOTIFY) |=> s_reinit;
  endproperty
  a_notify_reinit: assert property (p_notify_reinit) else $error("notify timeout did not reinit");

  property p_ready_no_err;
    @(posedge clk) disable iff (reset)
      (ready_ok && !err_ack) |=> err_flags == $past(err_flags);
  endproperty
  a_ready_no_err: assert property (p_ready_no_err) else $error("ready raised an error");

  property p_sticky;
    @(posedge clk) disable iff (reset)
      (err_flags != 4'h0 && !err_ack) |=> (err_flags & $past(err_flags)) == $past(err_flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag lost");

  // One write pulse carrying the read mode value, then the done pulse
  sequence s_mode_write;
    (mode_entry_we && mode_entry_data == `FOTS_READ_MODE_VALUE) ##1 (op_done && !mode_entry_we);
  endsequence

  property p_mode_write;
    @(posedge clk) disable iff (reset)
      (ready_ok && cur_op == FOTS_OP_READMODE) |=> s_mode_write;
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("read mode write missing");

  property p_timeout_exact;
    @(posedge clk) disable iff (reset)
      timeout |-> count == limit - 32'd1;
  endproperty
  a_timeout_exact: assert property (p_timeout_exact) else $error("timeout at wrong count");

  property p_err_kind;
    @(posedge clk) disable iff (reset)
      (timeout && cur_op == FOTS_OP_PROG) |=> err_flags[`FOTS_ERR_PROG];
  endproperty
  a_err_kind: assert property (p_err_kind) else $error("program timeout not flagged");

  property p_erase_err;
    @(posedge clk) disable iff (reset)
      (timeout && cur_op == FOTS_OP_ERASE) |=> err_flags[`FOTS_ERR_ERASE];
  endproperty
  a_erase_err: assert property (p_erase_err) else $error("erase timeout not flagged");

  // A timed out read mode return must not write the mode entry register
  property p_readmode_err;
    @(posedge clk) disable iff (reset)
      (timeout && cur_op == FOTS_OP_READMODE) |=> (err_flags[`FOTS_ERR_READMODE] && !mode_entry_we);
  endproperty
  a_readmode_err: assert property (p_readmode_err) else $error("read mode timeout not flagged");

  // Acknowledge and a new timeout in one cycle leave only the new flag
  property p_set_wins;
    @(posedge clk) disable iff (reset)
      (timeout && err_ack) |=> err_flags == (4'h1 << cur_op);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("timeout lost to acknowledge");

endmodule // fots_supervisor

// *** bench/fots_flash_model.sv ***
/*
  Behavioural flash control unit facing the supervisor.
  Assumes cmd pulses only while the supervisor is idle; delay 0 means never ready.
*/
`timescale 1ns/1ps
module fots_flash_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        cmd,
  input  wire logic        flash_reset_bit,
  input  wire logic [31:0] delay,
  output logic             flash_ready_flag
);
  logic [31:0] cnt;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 32'h0;
      flash_ready_flag <= 1'b1;
    end else if (flash_reset_bit) begin
      cnt <= 32'h1;
      flash_ready_flag <= 1'b0;
    end else if (cmd) begin
      cnt <= delay;
      flash_ready_flag <= 1'b0;
    end else if (cnt == 32'h1) begin
      cnt <= 32'h0;
      flash_ready_flag <= 1'b1;
    end else if (cnt > 32'h1) begin
      cnt <= cnt - 32'h1;
    end
  end
endmodule // fots_flash_model

// *** bench/fots_supervisor_tb_top.sv ***
/*
  Self-checking bench for the flash operation timeout supervisor.
  Assumes the short window parameters 20, 10, 40 and 30 cycles.
*/
`timescale 1ns/1ps
module fots_supervisor_tb_top;
  import fots_pkg::*;
  logic        clk = 0, reset = 1, op_start = 0, init_start = 0, err_ack = 0;
  fots_op_t    op_kind = FOTS_OP_NOTIFY;
  int          dly = 0, err_total = 0, compares = 0, took, rst_len;
  logic        ready, rst_bit, we, busy, done, we_seen;
  logic [15:0] data;
  logic [3:0]  errs;
  always #4 clk = ~clk;
  fots_supervisor #(.NOTIFY_CYC(20), .RESET_CYC(10), .ERASE_CYC(40), .PROG_CYC(30)) uut (
    .clk(clk), .reset(reset), .op_start(op_start), .op_kind(op_kind), .init_start(init_start),
    .err_ack(err_ack), .flash_ready_flag(ready), .flash_reset_bit(rst_bit), .mode_entry_we(we),
    .mode_entry_data(data), .busy(busy), .op_done(done), .err_flags(errs));
  fots_flash_model fu (.clk(clk), .reset(reset), .cmd(op_start), .flash_reset_bit(rst_bit),
    .delay(dly), .flash_ready_flag(ready));
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Issues one request and follows it to op_done, noting reset pulse and mode write
  task automatic run(fots_op_t k, int d, logic by_init);
    @(negedge clk);
    op_kind = k;
    dly = d;
    op_start = !by_init;
    init_start = by_init;
    @(negedge clk);
    op_start = 0;
    init_start = 0;
    took = 1;
    rst_len = 0;
    we_seen = 0;
    while (done !== 1'b1 && took < 300) begin
      rst_len += int'(rst_bit);
      if (we === 1'b1) begin
        we_seen = 1;
        chk("mode data", 16'hAA00, data);
      end
      @(negedge clk);
      took++;
    end
    chk("op done", 1'h1, done);
    @(negedge clk);
  endtask
  task automatic t_ack;
    err_ack = 1;
    @(negedge clk);
    err_ack = 0;
    chk("flags after ack", 4'h0, errs);
  endtask
  task automatic t_erase;
    run(FOTS_OP_ERASE, 5, 0);
    chk("erase flags", 4'h0, errs);
    chk("erase early end", 1'h1, took < 40);
    run(FOTS_OP_ERASE, 0, 0);
    chk("erase timeout", 4'h2, errs);
    chk("erase window", 1'h1, took >= 40);
    t_ack();
  endtask
  task automatic t_prog;
    run(FOTS_OP_PROG, 4, 0);
    chk("program flags", 4'h0, errs);
    run(FOTS_OP_PROG, 0, 0);
    chk("program timeout", 4'h4, errs);
    chk("program window", 1'h1, took >= 30);
    t_ack();
  endtask
  task automatic t_notify;
    run(FOTS_OP_NOTIFY, 0, 0);
    chk("notify timeout", 4'h1, errs);
    chk("notify window", 1'h1, took >= 20);
    chk("reinit pulse", 16'h000A, 16'(rst_len));
    t_ack();
  endtask
  task automatic t_readmode;
    run(FOTS_OP_READMODE, 3, 0);
    chk("mode written", 1'h1, we_seen);
    chk("read mode flags", 4'h0, errs);
    run(FOTS_OP_READMODE, 0, 0);
    chk("no write on timeout", 1'h0, we_seen);
    chk("read mode timeout", 4'h8, errs);
    t_ack();
  endtask
  task automatic t_init;
    run(FOTS_OP_NOTIFY, 0, 1);
    chk("reset pulse", 16'h000A, 16'(rst_len));
    chk("init flags", 4'h0, errs);
  endtask
  // Acknowledge held over the edge on which a program times out: old flag goes, new one stays
  task automatic t_collide;
    run(FOTS_OP_ERASE, 0, 0);
    chk("flag before ack", 4'h2, errs);
    @(negedge clk);
    op_kind = FOTS_OP_PROG;
    dly = 0;
    op_start = 1;
    @(negedge clk);
    op_start = 0;
    repeat (29) @(negedge clk);
    err_ack = 1;
    @(negedge clk);
    err_ack = 0;
    chk("set wins over ack", 4'h4, errs);
    chk("collide done", 1'h1, done);
    @(negedge clk);
    t_ack();
  endtask
  // A request while busy is ignored, flags stay, and a mid-run reset clears everything
  task automatic t_reset;
    run(FOTS_OP_PROG, 0, 0);
    @(negedge clk);
    op_kind = FOTS_OP_ERASE;
    dly = 0;
    op_start = 1;
    @(negedge clk);
    op_start = 0;
    init_start = 1;
    @(negedge clk);
    init_start = 0;
    chk("refused init", 1'h0, rst_bit);
    chk("busy in erase", 1'h1, busy);
    chk("sticky flags", 4'h4, errs);
    reset = 1;
    @(negedge clk);
    chk("outputs in reset", 8'h00, {busy, done, we, rst_bit, errs});
    reset = 0;
    @(negedge clk);
    chk("data after reset", 16'h0000, data);
    chk("idle after reset", 2'h0, {busy, done});
    run(FOTS_OP_ERASE, 2, 0);
    chk("erase after reset", 4'h0, errs);
    chk("erase after reset end", 1'h1, took < 40);
  endtask
  task stop_test;
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    reset = 0;
    chk("idle outputs", 0, {busy, done, we, rst_bit, errs});
    t_init();
    t_erase();
    t_prog();
    t_notify();
    t_readmode();
    t_collide();
    t_reset();
    stop_test();
  end
  // Whole sequence needs well under 1000 cycles
  initial begin
    #40000;
    err_total++;
    stop_test();
  end
endmodule // fots_supervisor_tb_top
